/* File: rtl/rx_filter_pkg.sv */
// constants and types for the receive frame filter
package rx_filter_pkg;

  // ----------------------------------------
  // register map (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFF_FILT = 12'h000;
  localparam logic [11:0] OFF_RXCTL = 12'h004;
  localparam logic [11:0] OFF_STA_LO = 12'h008;
  localparam logic [11:0] OFF_STA_HI = 12'h00C;
  localparam logic [11:0] OFF_HASH = 12'h010;
  localparam logic [11:0] OFF_STAT = 12'h020;
  localparam int NUM_HASH_WORDS = 4;

  // ----------------------------------------
  // filter control fields and reset values
  // ----------------------------------------
  localparam logic [15:0] FILT_RESET = 16'h0059;
  localparam logic [15:0] FILT_MASK = 16'hDFFF;
  localparam int B_HASH = 15;
  localparam int B_WAKE = 14;
  localparam int B_PINV = 12;
  localparam int B_PM_LO = 8;
  localparam int B_CRCC = 7;
  localparam int B_CRCR = 6;
  localparam int B_RUNC = 5;
  localparam int B_RUNR = 4;
  localparam int B_UC = 3;
  localparam int B_NOTME = 2;
  localparam int B_MC = 1;
  localparam int B_BC = 0;

  // ----------------------------------------
  // frame geometry and crc
  // ----------------------------------------
  localparam logic [10:0] DA_LEN = 11'h006;
  localparam logic [10:0] MIN_LEN = 11'h040;
  localparam logic [10:0] CNT_MAX = 11'h7FF;
  localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hC704DD7B;
  localparam int HASH_HI = 28;
  localparam int HASH_LO = 23;

  typedef enum logic [3:0] {
    PM_OFF = 4'h0, PM_CSUM = 4'h1, PM_UC = 4'h2, PM_NUC = 4'h3,
    PM_MC = 4'h4, PM_NMC = 4'h5, PM_BC = 4'h6, PM_NBC = 4'h7,
    PM_HASH = 4'h8, PM_WAKE = 4'h9
  } pm_e;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_RECV = 3'b010, ST_DECIDE = 3'b100
  } fsm_e;

  typedef struct packed {
    logic sof;
    logic eof;
    logic [7:0] data;
  } rx_beat_s;

endpackage

/* File: rtl/rx_crc32.sv */
// byte-wide crc-32 engine, data bits taken lsb first
`timescale 1ns/10ps
`default_nettype none
module rx_crc32 (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic start,
  input wire logic step,
  input wire logic [7:0] data,
  output logic [31:0] crc
);
  import rx_filter_pkg::*;

  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = r[31] ^ d[i];
      r = {r[30:0], 1'b0};
      if (fb) begin
        r = r ^ CRC_POLY;
      end
    end
    return r;
  endfunction

  // start restarts from the seed so a new frame never inherits old state
  wire logic [31:0] base = start ? CRC_INIT : crc;
  wire logic [31:0] crc_nxt = step ? crc_byte(base, data) : base;

  always_ff @(posedge CLK) begin
    if (SRST) begin
      crc <= CRC_INIT;
    end else begin
      crc <= crc_nxt;
    end
  end

endmodule // rx_crc32
`default_nettype wire

/* File: rtl/rx_frame_filter.sv */
// receive frame filter chain with apb register slave
// ----------------------------------------
// ----------------------------------------
`timescale 1ns/10ps
`default_nettype none
module rx_frame_filter (
  input wire logic CLK,
  input wire logic SRST,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic RX_VALID,
  input wire rx_filter_pkg::rx_beat_s RX_BEAT,
  input wire logic PAT_CSUM_OK,
  input wire logic WAKE_FOUND,
  output logic FRAME_COMMIT,
  output logic FRAME_DROP,
  output logic RX_BUSY
);
  import rx_filter_pkg::*;

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  logic [15:0] rx_filter_control_r;
  logic receive_enable_r;
  logic [47:0] station_address_r;
  logic [15:0] hash_table_word_r [NUM_HASH_WORDS];
  logic [7:0] accept_cnt_r;
  logic last_accept_r;
  logic last_crc_bad_r;
  logic last_short_r;
  fsm_e state_r;

  wire logic setup = PSEL & ~PENABLE;
  wire logic wr_go = PSEL & PENABLE & PREADY & PWRITE & ~PSLVERR;
  wire logic sel_filt = PADDR == OFF_FILT;
  wire logic sel_rxctl = PADDR == OFF_RXCTL;
  wire logic sel_sta_lo = PADDR == OFF_STA_LO;
  wire logic sel_sta_hi = PADDR == OFF_STA_HI;
  wire logic sel_stat = PADDR == OFF_STAT;
  wire logic [3:0] hash_sel;
  wire logic [15:0] hash_rd;
  wire logic [63:0] hash_flat;

  genvar g;
  generate
    for (g = 0; g < NUM_HASH_WORDS; g++) begin : g_hash
      assign hash_sel[g] = PADDR == OFF_HASH + 12'(4 * g);
      assign hash_flat[16*g +: 16] = hash_table_word_r[g];
      always_ff @(posedge CLK) begin
        if (SRST) begin
          hash_table_word_r[g] <= 16'h0000;
        end else if (wr_go && hash_sel[g]) begin
          hash_table_word_r[g] <= PWDATA[15:0];
        end
      end
    end
  endgenerate

  assign hash_rd = (|hash_sel) ? hash_table_word_r[PADDR[3:2]] : 16'h0000;

  wire logic hit = sel_filt | sel_rxctl | sel_sta_lo | sel_sta_hi
                 | sel_stat | (|hash_sel);
  wire logic [31:0] status_word = {16'h0000, accept_cnt_r, 4'h0, last_short_r,
                                   last_crc_bad_r, last_accept_r, state_r != ST_IDLE};
  wire logic [31:0] rd_word =
    sel_filt   ? {16'h0000, rx_filter_control_r} :
    sel_rxctl  ? {31'h00000000, receive_enable_r} :
    sel_sta_lo ? station_address_r[31:0] :
    sel_sta_hi ? {16'h0000, station_address_r[47:32]} :
    sel_stat   ? status_word :
    {16'h0000, hash_rd};

  // answer in the first access cycle, no wait states
  always_ff @(posedge CLK) begin
    if (SRST) begin
      PREADY <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA <= 32'h00000000;
    end else begin
      PREADY <= setup;
      PSLVERR <= setup & ~hit;
      PRDATA <= setup ? rd_word : 32'h00000000;
    end
  end

  // ----------------------------------------
  // control registers
  // ----------------------------------------
  always_ff @(posedge CLK) begin
    if (SRST) begin
      rx_filter_control_r <= FILT_RESET;
      receive_enable_r <= 1'b0;
      station_address_r <= 48'h000000000000;
    end else if (wr_go) begin
      if (sel_filt) begin
        rx_filter_control_r <= PWDATA[15:0] & FILT_MASK;
      end
      if (sel_rxctl) begin
        receive_enable_r <= PWDATA[0];
      end
      if (sel_sta_lo) begin
        station_address_r[31:0] <= PWDATA;
      end
      if (sel_sta_hi) begin
        station_address_r[47:32] <= PWDATA[15:0];
      end
    end
  end

  // ----------------------------------------
  // frame tracking
  // ----------------------------------------
  logic [10:0] byte_cnt_r;
  logic [47:0] da_r;
  wire logic [31:0] hash_crc;
  wire logic [31:0] fcs_crc;

  wire logic first = RX_VALID & RX_BEAT.sof;
  wire logic more = RX_VALID & ~RX_BEAT.sof & (state_r == ST_RECV);
  wire logic last = (first | more) & RX_BEAT.eof;
  wire logic in_da = byte_cnt_r < DA_LEN;
  wire logic [10:0] cnt_inc = (byte_cnt_r == CNT_MAX) ? CNT_MAX
                            : 11'(byte_cnt_r + 11'h001);

  fsm_e state_nxt;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: state_nxt = first ? (RX_BEAT.eof ? ST_DECIDE : ST_RECV) : ST_IDLE;
      ST_RECV: state_nxt = last ? ST_DECIDE : ST_RECV;
      ST_DECIDE: state_nxt = first ? (RX_BEAT.eof ? ST_DECIDE : ST_RECV) : ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // destination bytes land first-on-wire in the low byte
  always_ff @(posedge CLK) begin
    if (SRST) begin
      byte_cnt_r <= 11'h000;
      da_r <= 48'h000000000000;
    end else if (first) begin
      byte_cnt_r <= 11'h001;
      da_r <= {40'h0000000000, RX_BEAT.data};
    end else if (more) begin
      byte_cnt_r <= cnt_inc;
      if (in_da) begin
        da_r[8*byte_cnt_r[2:0] +: 8] <= RX_BEAT.data;
      end
    end
  end

  rx_crc32 u_hash_crc (
    .CLK(CLK),
    .SRST(SRST),
    .start(first),
    .step(first | (more & in_da)),
    .data(RX_BEAT.data),
    .crc(hash_crc)
  );

  // whole frame incl. check bytes; good frame leaves the residue
  rx_crc32 u_fcs_crc (
    .CLK(CLK),
    .SRST(SRST),
    .start(first),
    .step(first | more),
    .data(RX_BEAT.data),
    .crc(fcs_crc)
  );

  // ----------------------------------------
  // filter decisions
  // ----------------------------------------
  wire logic [15:0] fc = rx_filter_control_r;
  wire logic deciding = state_r == ST_DECIDE;
  wire logic crc_bad = fcs_crc != CRC_RESIDUE;
  wire logic is_short = byte_cnt_r < DA_LEN + MIN_LEN;
  wire logic da_me = da_r == station_address_r;
  wire logic da_mc = da_r[0];
  wire logic da_bc = &da_r;
  wire logic da_notme = ~da_mc & ~da_me;
  wire logic hash_bit = hash_flat[hash_crc[HASH_HI:HASH_LO]];

  function automatic logic pm_cond(input logic [3:0] mode,
                                   input logic me, input logic mc,
                                   input logic bc, input logic hb,
                                   input logic wk);
    logic r;
    r = 1'b0;
    unique case (mode)
      PM_CSUM: r = 1'b1;
      PM_UC: r = me;
      PM_NUC: r = ~me;
      PM_MC: r = mc;
      PM_NMC: r = ~mc;
      PM_BC: r = bc;
      PM_NBC: r = ~bc;
      PM_HASH: r = hb;
      PM_WAKE: r = wk;
      default: r = 1'b0;
    endcase
    return r;
  endfunction

  wire logic [3:0] pm_mode = fc[B_PM_LO +: 4];
  wire logic csum_ok = PAT_CSUM_OK ^ fc[B_PINV];
  wire logic pm_hit = csum_ok
                    & pm_cond(pm_mode, da_me, da_mc, da_bc, hash_bit, WAKE_FOUND);

  // collection filters only raise accept terms
  wire logic uc_hit = fc[B_UC] & da_me;
  wire logic notme_hit = fc[B_NOTME] & da_notme;
  wire logic mc_hit = fc[B_MC] & da_mc;
  wire logic bc_hit = fc[B_BC] & da_bc;
  wire logic ht_hit = fc[B_HASH] & hash_bit;
  wire logic wk_hit = fc[B_WAKE] & WAKE_FOUND;
  wire logic collect_hit = uc_hit | notme_hit | mc_hit | bc_hit
                         | ht_hit | wk_hit | pm_hit;

  wire logic force_accept = (fc[B_CRCC] & crc_bad) | (fc[B_RUNC] & is_short);
  wire logic force_drop = (fc[B_CRCR] & crc_bad) | (fc[B_RUNR] & is_short);

  // frame is dropped while receive is off
  wire logic accept = receive_enable_r
                    & (force_accept | (~force_drop & collect_hit));

  // ----------------------------------------
  // outcome
  // ----------------------------------------
  // one pulse after the last byte
  always_ff @(posedge CLK) begin
    if (SRST) begin
      FRAME_COMMIT <= 1'b0;
      FRAME_DROP <= 1'b0;
      RX_BUSY <= 1'b0;
    end else begin
      FRAME_COMMIT <= deciding & accept;
      FRAME_DROP <= deciding & ~accept;
      RX_BUSY <= state_nxt != ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      accept_cnt_r <= 8'h00;
      last_accept_r <= 1'b0;
      last_crc_bad_r <= 1'b0;
      last_short_r <= 1'b0;
    end else if (deciding) begin
      accept_cnt_r <= 8'(accept_cnt_r + {7'h00, accept});
      last_accept_r <= accept;
      last_crc_bad_r <= crc_bad;
      last_short_r <= is_short;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  a_reset_filter_value: assert property (
    $past(SRST) |-> rx_filter_control_r == FILT_RESET)
    else $error("filter control not at reset value");
  a_crc_collect_wins: assert property (
    deciding && receive_enable_r && fc[B_CRCC] && crc_bad |=> FRAME_COMMIT)
    else $error("bad crc frame not accepted");
  a_crc_reject_drops: assert property (
    deciding && fc[B_CRCR] && crc_bad && !fc[B_CRCC]
    && !(fc[B_RUNC] && is_short) |=> FRAME_DROP && !FRAME_COMMIT)
    else $error("bad crc frame not dropped");
  a_runt_collect_wins: assert property (
    deciding && receive_enable_r && fc[B_RUNC]
    && byte_cnt_r <= 11'h045 |=> FRAME_COMMIT)
    else $error("short frame not accepted");
  a_runt_reject_drops: assert property (
    deciding && fc[B_RUNR] && is_short && !fc[B_RUNC]
    && !(fc[B_CRCC] && crc_bad) |=> FRAME_DROP)
    else $error("short frame not dropped");
  a_nothing_accepts: assert property (
    deciding && !force_accept && !collect_hit |=> FRAME_DROP)
    else $error("unaccepted frame committed");
  a_bcast_accepts: assert property (
    deciding && receive_enable_r && !force_drop && fc[B_BC] && da_bc
    |=> FRAME_COMMIT)
    else $error("broadcast frame not accepted");
  a_outcome_after_end: assert property (
    FRAME_COMMIT || FRAME_DROP |-> $past(deciding) && !(FRAME_COMMIT && FRAME_DROP))
    else $error("outcome without frame end");
  a_reserved_mode_off: assert property (
    pm_mode > 4'h9 |-> !pm_hit)
    else $error("reserved pattern mode matched");

  c_crc_collect: cover property (deciding && crc_bad && fc[B_CRCC] ##1 FRAME_COMMIT);
  c_runt_drop: cover property (deciding && is_short && fc[B_RUNR] ##1 FRAME_DROP);
  c_hash_accept: cover property (deciding && ht_hit && !force_drop ##1 FRAME_COMMIT);

endmodule // rx_frame_filter
`default_nettype wire

/* File: tb/rx_mac_model.sv */
// behavioural mac receive side that streams frames into the filter
`timescale 1ns/10ps
`default_nettype none
module rx_mac_model (
  input wire logic CLK,
  output logic RX_VALID,
  output var rx_filter_pkg::rx_beat_s RX_BEAT,
  output logic PAT_CSUM_OK,
  output logic WAKE_FOUND
);
  import rx_filter_pkg::*;

  initial begin
    RX_VALID = 1'b0;
    RX_BEAT = '0;
    PAT_CSUM_OK = 1'b0;
    WAKE_FOUND = 1'b0;
  end

  // ----------------------------------------
  // crc helpers
  // ----------------------------------------
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] b);
    logic fb;
    for (int j = 0; j < 8; j++) begin
      fb = c[31] ^ b[j];
      c = {c[30:0], 1'b0} ^ (fb ? CRC_POLY : 32'h00000000);
    end
    return c;
  endfunction

  // fcs goes out inverted, msb of the register first on the wire
  function automatic logic [7:0] fcs_byte(input logic [31:0] c, input int k);
    logic [7:0] f;
    for (int j = 0; j < 8; j++) begin
      f[j] = ~c[31 - 8 * k - j];
    end
    return f;
  endfunction

  // ----------------------------------------
  // frame sender
  // ----------------------------------------
  // destination first, fcs last
  task automatic send(input logic [47:0] da, input int len, input logic bad,
                      input logic cs, input logic wk, input logic slow);
    logic [7:0] b;
    logic [31:0] c;
    c = CRC_INIT;
    for (int i = 0; i < len; i++) begin
      if (i < 6) b = da[47 - 8 * i -: 8];
      else if (i < len - 4) b = i[7:0];
      else b = fcs_byte(c, i - (len - 4)) ^ {7'h00, bad};
      if (i < len - 4) c = crc_byte(c, b);
      @(posedge CLK);
      RX_VALID <= 1'b1;
      RX_BEAT <= '{sof: (i == 0), eof: (i == len - 1), data: b};
      PAT_CSUM_OK <= cs;
      WAKE_FOUND <= wk;
      // idle beats carry garbage so stale data never looks valid
      if (slow && i < len - 1) begin
        @(posedge CLK);
        RX_VALID <= 1'b0;
        RX_BEAT.data <= ~b;
      end
    end
    @(posedge CLK);
    RX_VALID <= 1'b0;
    RX_BEAT <= '{sof: 1'b0, eof: 1'b0, data: ~b};
  endtask
endmodule // rx_mac_model
`default_nettype wire

/* File: tb/rx_frame_filter_tb_top.sv */
// self-checking bench for the receive frame filter
`timescale 1ns/10ps
`default_nettype none
module rx_frame_filter_tb_top;
  import rx_filter_pkg::*;

  // flg: bad fcs, csum ok, wake, receive on, accept expected
  typedef struct packed {
    logic [15:0] cfg;
    logic [1:0] da;
    logic [7:0] len;
    logic [4:0] flg;
  } row_s;

  localparam logic [47:0] DAS [4] = '{48'h021122334455, 48'h0211223344AA,
                                      48'hFFFFFFFFFFFF, 48'h01000000012C};
  localparam row_s TBL [34] = '{
    '{16'h0059, 2'h0, 8'h46, 5'h03},
    '{16'h0059, 2'h0, 8'h45, 5'h02},
    '{16'h0059, 2'h0, 8'h46, 5'h12},
    '{16'h0059, 2'h2, 8'h46, 5'h03},
    '{16'h0059, 2'h1, 8'h46, 5'h02},
    '{16'h0059, 2'h3, 8'h46, 5'h02},
    '{16'h0059, 2'h0, 8'h46, 5'h00},
    '{16'h0004, 2'h1, 8'h46, 5'h03},
    '{16'h0004, 2'h3, 8'h46, 5'h02},
    '{16'h0002, 2'h3, 8'h46, 5'h03},
    '{16'h0002, 2'h1, 8'h46, 5'h02},
    '{16'h00C0, 2'h0, 8'h46, 5'h13},
    '{16'h0080, 2'h1, 8'h46, 5'h02},
    '{16'h0030, 2'h1, 8'h3C, 5'h03},
    '{16'h0018, 2'h0, 8'h3C, 5'h02},
    '{16'h0010, 2'h0, 8'h46, 5'h02},
    '{16'h8000, 2'h3, 8'h46, 5'h03},
    '{16'h0000, 2'h3, 8'h46, 5'h0E},
    '{16'h4000, 2'h1, 8'h46, 5'h07},
    '{16'h4000, 2'h1, 8'h46, 5'h02},
    '{16'h0100, 2'h1, 8'h46, 5'h0B},
    '{16'h0100, 2'h1, 8'h46, 5'h02},
    '{16'h1100, 2'h1, 8'h46, 5'h03},
    '{16'h1100, 2'h1, 8'h46, 5'h0A},
    '{16'h0200, 2'h0, 8'h46, 5'h0B},
    '{16'h0300, 2'h0, 8'h46, 5'h0A},
    '{16'h0400, 2'h3, 8'h46, 5'h0B},
    '{16'h0500, 2'h3, 8'h46, 5'h0A},
    '{16'h0600, 2'h2, 8'h46, 5'h0B},
    '{16'h0700, 2'h2, 8'h46, 5'h0A},
    '{16'h0800, 2'h3, 8'h46, 5'h0B},
    '{16'h0900, 2'h1, 8'h46, 5'h0F},
    '{16'h0A00, 2'h1, 8'h46, 5'h0E},
    '{16'h0F00, 2'h1, 8'h46, 5'h0E}
  };

  logic clk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_valid;
  rx_beat_s rx_beat;
  logic pat_csum_ok;
  logic wake_found;
  logic frame_commit;
  logic frame_drop;
  logic rx_busy;
  int n_mismatch = 0;
  int n_tests = 0;

  rx_frame_filter uut (.CLK(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .RX_VALID(rx_valid), .RX_BEAT(rx_beat),
    .PAT_CSUM_OK(pat_csum_ok), .WAKE_FOUND(wake_found),
    .FRAME_COMMIT(frame_commit), .FRAME_DROP(frame_drop), .RX_BUSY(rx_busy));

  rx_mac_model mac (.CLK(clk), .RX_VALID(rx_valid), .RX_BEAT(rx_beat),
    .PAT_CSUM_OK(pat_csum_ok), .WAKE_FOUND(wake_found));

  initial begin
    forever #50 clk = ~clk;
  end

  // ----------------------------------------
  // bus and compare tasks
  // ----------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // wait for the answer however long; only the watchdog ends a hang
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_frame(input logic [2:0] got, input logic [2:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    #5000000;
    n_mismatch++;
    wrap_up();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] rd;
    logic err;
    row_s r;
    int acc_cnt;
    acc_cnt = 0;
    repeat (8) @(posedge clk);
    srst <= 1'b0;
    apb(1'b0, OFF_FILT, 32'h00000000, rd, err);
    cmp_reg(rd, 32'h00000059);
    apb(1'b1, OFF_FILT, 32'h0000FFFF, rd, err);
    apb(1'b0, OFF_FILT, 32'h00000000, rd, err);
    cmp_reg(rd, 32'h0000DFFF);
    apb(1'b0, 12'h030, 32'h00000000, rd, err);
    cmp_reg({rd[30:0], err}, 32'h00000001);
    apb(1'b1, OFF_STA_LO, 32'h33221102, rd, err);
    apb(1'b1, OFF_STA_HI, 32'h00005544, rd, err);
    // hash pointer 34h lands in word four, bit 4
    apb(1'b1, OFF_HASH + 12'h00C, 32'h00000010, rd, err);
    apb(1'b0, OFF_HASH + 12'h00C, 32'h00000000, rd, err);
    cmp_reg(rd, 32'h00000010);
    for (int i = 0; i < 34; i++) begin
      r = TBL[i];
      apb(1'b1, OFF_RXCTL, 32'h00000000, rd, err);
      apb(1'b1, OFF_FILT, {16'h0000, r.cfg}, rd, err);
      apb(1'b1, OFF_RXCTL, {31'h00000000, r.flg[1]}, rd, err);
      mac.send(DAS[r.da], int'(r.len), r.flg[4], r.flg[3], r.flg[2], i[0]);
      // decide cycle: busy, no outcome yet
      #1;
      cmp_frame({frame_commit, frame_drop, rx_busy}, 3'b001);
      @(posedge clk);
      #1;
      cmp_frame({frame_commit, frame_drop, rx_busy}, {r.flg[0], ~r.flg[0], 1'b0});
      // outcome pulse lasts one cycle only
      @(posedge clk);
      #1;
      cmp_frame({frame_commit, frame_drop, rx_busy}, 3'b000);
      acc_cnt += int'(r.flg[0]);
    end
    apb(1'b0, OFF_STAT, 32'h00000000, rd, err);
    cmp_reg({24'h000000, rd[15:8]}, {24'h000000, acc_cnt[7:0]});
    wrap_up();
  end
endmodule // rx_frame_filter_tb_top
`default_nettype wire
